// ### pvc_pkg.sv
package pvc_pkg;
   localparam logic [4:0]  ADDR_SPEED_CONFIG  = 5'h14;
   localparam logic [4:0]  ADDR_RX_ERR_COUNT  = 5'h15;
   localparam logic [4:0]  ADDR_EXT_POINTER   = 5'h1E;
   localparam logic [4:0]  ADDR_EXTENDED_DATA_WINDOW      = 5'h1F;
   localparam logic [15:0] EXT_TEN_MEG_POWER  = 16'h200A;
   localparam logic [15:0] EXT_COMBO_CONTROL  = 16'h4000;
   localparam logic [15:0] EXT_PAD_CONTROL    = 16'h4001;

   // Speed config fields
   localparam int          SPC_LATCH_BIT      = 11;
   localparam int          SPC_DG_EN_BIT      = 5;
   localparam int          SPC_ATT_LSB        = 2;
   localparam int          SPC_BYPASS_BIT     = 1;
   localparam logic [15:0] SPC_WRITE_MASK     = 16'h0FFE;
   localparam logic [15:0] SPC_RESET          = 16'h082C;
   localparam logic [2:0]  ATTEMPT_EXTRA      = 3'h2;

   // Ten-meg power control
   localparam int          TMP_IDLE_BIT       = 10;
   localparam logic [15:0] TMP_RESET          = 16'hCA02;

   // Combo control
   localparam int          CMB_JUMBO_BIT      = 5;
   localparam int          CMB_CRS_SRC_BIT    = 4;
   localparam int          CMB_RMII_EN_BIT    = 1;
   localparam int          CMB_CLK_SEL_BIT    = 0;
   localparam logic [15:0] CMB_RESET          = 16'h0000;

   // Pad control
   localparam int          PAD_ROUTE_BIT      = 15;
   localparam int          PAD_MAC_DR_LSB     = 4;
   localparam int          PAD_MGMT_PAD_DRIVE_STRENGTH_LSB    = 2;
   localparam logic [15:0] PAD_RESET          = 16'h80EF;

   localparam logic [15:0] COUNT_MAX          = 16'hFFFF;
   localparam logic [15:0] JUMBO_LIMIT        = 16'h4800;
   localparam logic [15:0] NORMAL_LIMIT       = 16'h1200;

   // Link stability time, 2.5 s at 20 MHz
   localparam longint      STABLE_TIME_MS     = 2500;
   localparam longint      CLK_HZ             = 20000000;
   localparam int          STABLE_CYCLES      = int'((STABLE_TIME_MS * CLK_HZ) / 1000);

   typedef enum logic [1:0] {
      PVC_MII      = 2'b00,
      PVC_REDUCED_MODE_VARIANT_E    = 2'b01,
      PVC_RMII_TWO = 2'b10,
      PVC_RMII_ONE = 2'b11
   } pvc_mode_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  addr;
      logic [15:0] wdata;
   } pvc_mgmt_req_t;

   typedef struct packed {
      logic [1:0]  mac_drive;
      logic [1:0]  mgmt_drive;
   } pvc_pad_drive_t;
endpackage

// ### pvc_err_counter.sv
`timescale 1ns/1ps
module pvc_err_counter
   import pvc_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        event_i,
   input  wire logic        read_clear_i,
   output logic [15:0]      count_o
);
   logic [15:0] next_count;

   // Read clears, but an event in that cycle counts as one
   assign next_count = read_clear_i ? {15'h0000, event_i}
                     : (event_i && count_o != COUNT_MAX) ? count_o + 16'h0001
                     : count_o;

   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         count_o <= 16'h0000;
      else
         count_o <= next_count;
   end

   saturate_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (count_o == COUNT_MAX && !read_clear_i) |=> count_o == COUNT_MAX)
      else $error("error counter wrapped");
   read_clear_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      read_clear_i |=> count_o <= 16'h0001)
      else $error("error counter not cleared on read");
endmodule // pvc_err_counter

// ### pvc_downgrade.sv
`timescale 1ns/1ps
module pvc_downgrade
   import pvc_pkg::*;
#(
   parameter int STABLE_CNT = STABLE_CYCLES
)
(
   input  wire logic        core_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        enable_i,
   input  wire logic [2:0]  attempts_i,
   input  wire logic        bypass_i,
   input  wire logic        link_up_i,
   input  wire logic        an_fail_i,
   output logic [3:0]       retry_count_o,
   output logic             downgrade_o
);
   // Zero would make every link look stable at once
   if (STABLE_CNT < 1)
   begin : g_stable_chk
      $error("STABLE_CNT must be positive");
   end

   logic [31:0] hold_cnt;
   logic        link_q;
   logic [3:0]  limit;
   logic        early_drop;
   logic        fail_evt;

   assign limit      = {1'b0, attempts_i} + {1'b0, ATTEMPT_EXTRA};
   assign early_drop = link_q && !link_up_i && !bypass_i
                       && hold_cnt < 32'(STABLE_CNT);
   assign fail_evt   = enable_i && !downgrade_o && (an_fail_i || early_drop);

   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         hold_cnt      <= 32'h00000000;
         link_q        <= 1'b0;
         retry_count_o <= 4'h0;
         downgrade_o   <= 1'b0;
      end
      else
      begin
         link_q   <= link_up_i;
         hold_cnt <= !link_up_i ? 32'h00000000
                   : (hold_cnt < 32'(STABLE_CNT)) ? hold_cnt + 32'h00000001 : hold_cnt;
         if (fail_evt)
            retry_count_o <= retry_count_o + 4'h1;
         if (fail_evt && retry_count_o + 4'h1 >= limit)
            downgrade_o <= 1'b1;
      end
   end

   sequence early_loss_s;
      link_q && !link_up_i && !bypass_i && hold_cnt < 32'(STABLE_CNT);
   endsequence
   retry_step_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (enable_i && !downgrade_o && !an_fail_i) ##0 early_loss_s
      |=> retry_count_o == $past(retry_count_o) + 4'h1)
      else $error("early link loss not counted");
   no_enable_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !enable_i |=> $stable(downgrade_o))
      else $error("downgrade while disabled");
endmodule // pvc_downgrade

// ### pvc_vendor_regs.sv
`timescale 1ns/1ps
module pvc_vendor_regs
   import pvc_pkg::*;
#(
   parameter int STABLE_CNT = STABLE_CYCLES
)
(
   input  wire logic            core_clk_i,
   input  wire logic            rstn_i,
   input  wire logic            soft_reset_i,
   input  wire pvc_mgmt_req_t   mgmt_req_i,
   output pvc_mode_t            mac_mode_o,
   output logic [15:0]          mgmt_rdata_o,
   output logic                 mgmt_rvalid_o,
   input  wire logic            strap_clk_sel_i,
   input  wire logic            strap_rxd1_i,
   input  wire logic            rx_error_i,
   input  wire logic            link_up_i,
   input  wire logic            an_fail_i,
   input  wire logic            ten_meg_mode_i,
   input  wire logic            tx_activity_i,
   input  wire logic            rmii_crs_dv_i,
   input  wire logic            rmii_rx_dv_i,
   input  wire logic            gen_irq_i,
   input  wire logic            wake_irq_i,
   input  wire logic            scan_mode_i,
   input  wire logic [15:0]     live_value_i,
   output logic                 dac_on_o,
   output logic [15:0]          frame_limit_o,
   output logic                 crs_dv_pad_o,
   output logic                 mac_clk_input_o,
   output logic                 led0_o,
   output pvc_pad_drive_t       pad_drive_o,
   output logic                 downgrade_o,
   output logic [3:0]           retry_count_o
);
   logic [15:0] speed_config;
   logic [15:0] ext_pointer;
   logic [15:0] ten_meg_power;
   logic [15:0] combo_control;
   logic [15:0] pad_control;
   logic [15:0] capture;
   logic        dg_enable_live;
   logic [2:0]  attempts_live;
   logic        strap_taken;
   logic        strap_led;
   logic        rstn_q;
   logic [15:0] err_count;
   logic [3:0]  dg_retry;
   logic        dg_done;

   // Extended register access via pointer
   wire         wr_data   = mgmt_req_i.wr && mgmt_req_i.addr == ADDR_EXTENDED_DATA_WINDOW;
   wire         rd_err    = mgmt_req_i.rd && mgmt_req_i.addr == ADDR_RX_ERR_COUNT;
   wire         wr_speed  = mgmt_req_i.wr && mgmt_req_i.addr == ADDR_SPEED_CONFIG;
   wire         wr_ptr    = mgmt_req_i.wr && mgmt_req_i.addr == ADDR_EXT_POINTER;
   wire         sel_power = ext_pointer == EXT_TEN_MEG_POWER;
   wire         sel_combo = ext_pointer == EXT_COMBO_CONTROL;
   wire         sel_pad   = ext_pointer == EXT_PAD_CONTROL;
   wire         latch_en  = speed_config[SPC_LATCH_BIT];
   wire [15:0]  ext_rdata = sel_power ? ten_meg_power
                          : sel_combo ? combo_control
                          : sel_pad   ? pad_control : 16'h0000;
   wire [15:0]  reg_rdata = (mgmt_req_i.addr == ADDR_SPEED_CONFIG) ? speed_config
                          : (mgmt_req_i.addr == ADDR_RX_ERR_COUNT) ? err_count
                          : (mgmt_req_i.addr == ADDR_EXT_POINTER)  ? ext_pointer
                          : (mgmt_req_i.addr == ADDR_EXTENDED_DATA_WINDOW)     ? ext_rdata
                          : live_value_i;
   wire [1:0]   mode_bits = {combo_control[CMB_RMII_EN_BIT], combo_control[CMB_CLK_SEL_BIT]};
   wire         rmii_mode = combo_control[CMB_RMII_EN_BIT];
   wire         dac_idle  = ten_meg_mode_i && ten_meg_power[TMP_IDLE_BIT] && !tx_activity_i;

   // Latch off: answer follows the live value, no capture held
   wire [15:0]  read_value = latch_en ? capture : reg_rdata;

   pvc_err_counter u_err
   (
      .core_clk_i   (core_clk_i),
      .rstn_i       (rstn_i),
      .event_i      (rx_error_i),
      .read_clear_i (rd_err),
      .count_o      (err_count)
   );

   pvc_downgrade #(.STABLE_CNT(STABLE_CNT)) u_dg
   (
      .core_clk_i    (core_clk_i),
      .rstn_i        (rstn_i),
      .enable_i      (dg_enable_live),
      .attempts_i    (attempts_live),
      .bypass_i      (speed_config[SPC_BYPASS_BIT]),
      .link_up_i     (link_up_i),
      .an_fail_i     (an_fail_i),
      .retry_count_o (dg_retry),
      .downgrade_o   (dg_done)
   );

   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         capture <= 16'h0000;
      else if (mgmt_req_i.rd && latch_en)
         capture <= reg_rdata;
   end

   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         speed_config  <= SPC_RESET;
         ext_pointer   <= 16'h0000;
         ten_meg_power <= TMP_RESET;
         pad_control   <= PAD_RESET;
      end
      else
      begin
         if (wr_speed)
            speed_config <= (mgmt_req_i.wdata & SPC_WRITE_MASK)
                          | (speed_config & ~SPC_WRITE_MASK);
         if (wr_ptr)
            ext_pointer <= mgmt_req_i.wdata;
         if (wr_data && sel_power)
            ten_meg_power <= mgmt_req_i.wdata;
         if (wr_data && sel_pad)
            pad_control <= mgmt_req_i.wdata;
      end
   end

   // Strap caught one cycle after reset release, never under async reset
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rstn_q        <= 1'b0;
         strap_taken   <= 1'b0;
         strap_led     <= 1'b0;
         combo_control <= CMB_RESET;
      end
      else
      begin
         rstn_q <= 1'b1;
         if (!strap_taken)
         begin
            strap_taken   <= 1'b1;
            strap_led     <= strap_rxd1_i;
            combo_control <= CMB_RESET | (16'(strap_clk_sel_i) << CMB_CLK_SEL_BIT);
         end
         else if (wr_data && sel_combo)
            combo_control <= mgmt_req_i.wdata;
      end
   end

   // Enable and attempts copied only at software reset or power-up
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         dg_enable_live <= SPC_RESET[SPC_DG_EN_BIT];
         attempts_live  <= SPC_RESET[SPC_ATT_LSB +: 3];
      end
      else if (soft_reset_i)
      begin
         dg_enable_live <= speed_config[SPC_DG_EN_BIT];
         attempts_live  <= speed_config[SPC_ATT_LSB +: 3];
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         mgmt_rdata_o    <= 16'h0000;
         mgmt_rvalid_o   <= 1'b0;
         mac_mode_o      <= PVC_MII;
         dac_on_o        <= 1'b1;
         frame_limit_o   <= NORMAL_LIMIT;
         crs_dv_pad_o    <= 1'b0;
         mac_clk_input_o <= 1'b0;
         led0_o          <= 1'b0;
         pad_drive_o     <= '0;
         downgrade_o     <= 1'b0;
         retry_count_o   <= 4'h0;
      end
      else
      begin
         mgmt_rdata_o    <= mgmt_req_i.rd ? (latch_en ? reg_rdata : read_value) : mgmt_rdata_o;
         mgmt_rvalid_o   <= mgmt_req_i.rd;
         mac_mode_o      <= pvc_mode_t'(mode_bits);
         mac_clk_input_o <= combo_control[CMB_CLK_SEL_BIT];
         dac_on_o        <= !dac_idle;
         frame_limit_o   <= combo_control[CMB_JUMBO_BIT] ? JUMBO_LIMIT : NORMAL_LIMIT;
         crs_dv_pad_o    <= rmii_mode ? (combo_control[CMB_CRS_SRC_BIT] ? rmii_rx_dv_i
                                                                        : rmii_crs_dv_i)
                                      : 1'b0;
         led0_o          <= strap_led && (pad_control[PAD_ROUTE_BIT] ? gen_irq_i
                                                                      : wake_irq_i);
         if (!scan_mode_i)
            pad_drive_o  <= '{mac_drive:  pad_control[PAD_MAC_DR_LSB +: 2],
                              mgmt_drive: pad_control[PAD_MGMT_PAD_DRIVE_STRENGTH_LSB +: 2]};
         downgrade_o     <= dg_done;
         retry_count_o   <= dg_retry;
      end
   end

   sequence idle_cond_s;
      ten_meg_mode_i && ten_meg_power[TMP_IDLE_BIT] && !tx_activity_i;
   endsequence
   dac_idle_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      idle_cond_s |=> !dac_on_o)
      else $error("DAC left on while idle");
   dac_on_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !ten_meg_power[TMP_IDLE_BIT] |=> dac_on_o)
      else $error("DAC off with idle bit clear");
   jumbo_limit_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      combo_control[CMB_JUMBO_BIT] |=> frame_limit_o == JUMBO_LIMIT)
      else $error("jumbo limit wrong");
   carrier_src_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (rmii_mode && combo_control[CMB_CRS_SRC_BIT]) |=> crs_dv_pad_o == $past(rmii_rx_dv_i))
      else $error("carrier pad source wrong");
   mode_map_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      strap_taken |=> mac_mode_o == pvc_mode_t'($past(mode_bits)))
      else $error("interface mode mismatch");
   led_route_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (strap_led && !pad_control[PAD_ROUTE_BIT]) |=> led0_o == $past(wake_irq_i))
      else $error("LED0 routing wrong");
   pad_drive_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      scan_mode_i |=> $stable(pad_drive_o))
      else $error("drive codes changed in scan");
   pointer_write_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      wr_ptr |=> ext_pointer == $past(mgmt_req_i.wdata))
      else $error("pointer write lost");
   soft_apply_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !soft_reset_i |=> $stable(attempts_live) && $stable(dg_enable_live))
      else $error("downgrade setting applied without reset");
   read_latch_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (mgmt_req_i.rd && latch_en) |=> capture == $past(reg_rdata))
      else $error("read value not captured");
endmodule // pvc_vendor_regs

// ### pvc_mgmt_model.sv
`timescale 1ns/1ps
module pvc_mgmt_model
   import pvc_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rvalid_i,
   input  wire logic [15:0] rdata_i,
   output pvc_mgmt_req_t    req_o
);
   initial req_o = '0;

   // One-cycle request, launched just after an edge
   task automatic put(input logic w, input logic [4:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge core_clk_i);
      req_o <= '0;
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      put(1'b1, a, d);
   endtask

   // Unknown result if no answer comes, so a silent device fails
   task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
      d = 16'hXXXX;
      put(1'b0, a, 16'h0000);
      for (int n = 0; n < 8; n++)
      begin
         @(negedge core_clk_i);
         if (rvalid_i === 1'b1)
         begin
            d = rdata_i;
            break;
         end
      end
   endtask

   task automatic ext_wr(input logic [15:0] x, input logic [15:0] d);
      wr_reg(ADDR_EXT_POINTER, x);
      wr_reg(ADDR_EXTENDED_DATA_WINDOW, d);
   endtask

   task automatic ext_rd(input logic [15:0] x, output logic [15:0] d);
      wr_reg(ADDR_EXT_POINTER, x);
      rd_reg(ADDR_EXTENDED_DATA_WINDOW, d);
   endtask
endmodule // pvc_mgmt_model

// ### pvc_vendor_regs_tb.sv
`timescale 1ns/1ps
module pvc_vendor_regs_tb;
   import pvc_pkg::*;
   localparam int STB = 20;
   logic           clk = 1'b0;
   logic           rstn = 1'b0;
   logic           ten = 1'b0;
   logic           tx = 1'b0;
   logic           rxe = 1'b0;
   logic           anf = 1'b0;
   logic           lnk = 1'b0;
   logic           crs = 1'b0;
   logic           rdv = 1'b0;
   logic           gi = 1'b0;
   logic           wi = 1'b0;
   logic           scan = 1'b0;
   logic [15:0]    live = 16'h0000;
   pvc_mgmt_req_t  req;
   pvc_mode_t      mode;
   pvc_pad_drive_t drv;
   logic [15:0]    rdata;
   logic [15:0]    limit;
   logic [3:0]     retry;
   logic           rvalid, dac, cpad, cin, led, dg;
   int             err_total = 0;
   int             comparisons = 0;

   always #25 clk = ~clk;

   pvc_mgmt_model mac (.core_clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata), .req_o(req));

   pvc_vendor_regs #(.STABLE_CNT(STB)) pvc_vendor_regs_i (
      .core_clk_i(clk), .rstn_i(rstn), .soft_reset_i(1'b0), .mgmt_req_i(req),
      .mac_mode_o(mode), .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rvalid),
      .strap_clk_sel_i(1'b0), .strap_rxd1_i(1'b1), .rx_error_i(rxe),
      .link_up_i(lnk), .an_fail_i(anf), .ten_meg_mode_i(ten), .tx_activity_i(tx),
      .rmii_crs_dv_i(crs), .rmii_rx_dv_i(rdv), .gen_irq_i(gi), .wake_irq_i(wi),
      .scan_mode_i(scan), .live_value_i(live), .dac_on_o(dac), .frame_limit_o(limit),
      .crs_dv_pad_o(cpad), .mac_clk_input_o(cin), .led0_o(led), .pad_drive_o(drv),
      .downgrade_o(dg), .retry_count_o(retry));

   function automatic logic [15:0] limit_of(input logic j);
      return j ? JUMBO_LIMIT : NORMAL_LIMIT;
   endfunction

   // m is {source select, rmii enable, clock select}
   function automatic logic pad_of(input logic [2:0] m, input logic c, input logic r);
      return m[1] ? (m[2] ? r : c) : 1'b0;
   endfunction

   task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_pin(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Registered outputs need a couple of edges after an input change
   task automatic settle;
      repeat (3) @(negedge clk);
   endtask

   task automatic end_test(input string nm);
      $display("done %s", nm);
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      repeat (90000) @(posedge clk);
      err_total++;
      stop_test();
   end

   initial
   begin
      logic [15:0] d;
      logic [15:0] v;
      logic [2:0]  m;
      logic        b;
      int          n;
      n = $urandom(32);
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      mac.rd_reg(ADDR_EXT_POINTER, d);
      chk_reg("ext_ptr", 16'h0000, d);
      mac.rd_reg(ADDR_SPEED_CONFIG, d);
      chk_reg("spd_cfg", 16'h082C, d);
      mac.ext_rd(EXT_PAD_CONTROL, d);
      chk_reg("pad_ctl", 16'h80EF, d);
      mac.ext_rd(EXT_TEN_MEG_POWER, d);
      chk_reg("ten_pwr", 16'hCA02, d);
      mac.ext_rd(16'h1234, d);
      chk_reg("ext_unk", 16'h0000, d);
      chk_pin("drive", 16'h000B, 16'(drv));
      chk_pin("mode", 16'h0000, 16'(mode));
      end_test("reset");
      v = 16'($urandom);
      mac.wr_reg(ADDR_EXT_POINTER, v);
      mac.rd_reg(ADDR_EXT_POINTER, d);
      chk_reg("ext_ptr", v, d);
      for (int i = 0; i < 8; i++)
      begin
         m = 3'(i);
         v = {10'h000, m[0] ^ m[2], m[2], 2'b00, m[1:0]};
         mac.ext_wr(EXT_COMBO_CONTROL, v);
         mac.ext_rd(EXT_COMBO_CONTROL, d);
         chk_reg("combo", v, d);
         b = 1'($urandom);
         @(posedge clk);
         crs <= b;
         rdv <= !b;
         settle();
         chk_pin("mode", 16'(m[1:0]), 16'(mode));
         chk_pin("clk_dir", 16'(m[0]), 16'(cin));
         chk_pin("limit", limit_of(m[0] ^ m[2]), limit);
         chk_pin("crs_pad", 16'(pad_of(m, b, !b)), 16'(cpad));
      end
      end_test("modes");
      v = 16'($urandom);
      @(posedge clk);
      live <= v;
      fork
         mac.rd_reg(5'h10, d);
         begin
            repeat (2) @(posedge clk);
            live <= ~v;
         end
      join
      chk_reg("latched", v, d);
      for (int i = 1; i <= 5; i++)
      begin
         // First failure is a link that drops before it counts as stable
         if (i == 1)
         begin
            @(posedge clk);
            lnk <= 1'b1;
            repeat (3) @(posedge clk);
            lnk <= 1'b0;
         end
         else
         begin
            @(posedge clk);
            anf <= 1'b1;
            @(posedge clk);
            anf <= 1'b0;
         end
         settle();
         chk_pin("retry", 16'(i), 16'(retry));
         chk_pin("downgrade", 16'(i >= 5), 16'(dg));
      end
      mac.wr_reg(ADDR_SPEED_CONFIG, 16'hFFFF);
      mac.rd_reg(ADDR_SPEED_CONFIG, d);
      chk_reg("spd_cfg", 16'h0FFE, d);
      mac.wr_reg(ADDR_SPEED_CONFIG, 16'h002C);
      mac.rd_reg(ADDR_SPEED_CONFIG, d);
      chk_reg("spd_cfg", 16'h002C, d);
      mac.rd_reg(5'h10, d);
      chk_reg("unlatched", ~v, d);
      end_test("speed");
      n = $urandom_range(40, 3);
      @(posedge clk);
      rxe <= 1'b1;
      repeat (n) @(posedge clk);
      rxe <= 1'b0;
      mac.rd_reg(ADDR_RX_ERR_COUNT, d);
      chk_reg("rx_err", 16'(n), d);
      mac.rd_reg(ADDR_RX_ERR_COUNT, d);
      chk_reg("rx_err", 16'h0000, d);
      @(posedge clk);
      rxe <= 1'b1;
      repeat (65540) @(posedge clk);
      rxe <= 1'b0;
      mac.rd_reg(ADDR_RX_ERR_COUNT, d);
      chk_reg("rx_err", COUNT_MAX, d);
      end_test("errors");
      @(posedge clk);
      gi <= 1'b1;
      settle();
      chk_pin("led0", 16'h0001, 16'(led));
      v = {12'h000, 4'($urandom)};
      mac.ext_wr(EXT_PAD_CONTROL, {1'b0, 9'h003, v[3:0], 2'b11});
      settle();
      chk_pin("led0", 16'h0000, 16'(led));
      chk_pin("drive", v, 16'(drv));
      @(posedge clk);
      scan <= 1'b1;
      mac.ext_wr(EXT_PAD_CONTROL, {1'b1, 9'h003, ~v[3:0], 2'b11});
      settle();
      chk_pin("drive", v, 16'(drv));
      chk_pin("led0", 16'h0001, 16'(led));
      @(posedge clk);
      scan <= 1'b0;
      settle();
      chk_pin("drive", {12'h000, ~v[3:0]}, 16'(drv));
      end_test("pads");
      @(posedge clk);
      ten <= 1'b1;
      settle();
      chk_pin("dac", 16'h0001, 16'(dac));
      mac.ext_wr(EXT_TEN_MEG_POWER, 16'hCE02);
      settle();
      chk_pin("dac", 16'h0000, 16'(dac));
      @(posedge clk);
      tx <= 1'b1;
      settle();
      chk_pin("dac", 16'h0001, 16'(dac));
      @(posedge clk);
      tx <= 1'b0;
      ten <= 1'b0;
      settle();
      chk_pin("dac", 16'h0001, 16'(dac));
      end_test("power");
      stop_test();
   end
endmodule // pvc_vendor_regs_tb
